// >>> common/drt_consts.svh
`ifndef DRT_CONSTS_SVH
`define DRT_CONSTS_SVH

`define DRT_NUM_BANKS 8
`define DRT_BANK_W 3
`define DRT_LAST_BANK 3'h7
`define DRT_ROW_W 16
`define DRT_ROW_RESET 16'h0000
`define DRT_BANK_RESET 3'h0
`define DRT_CA_W 6
`define DRT_REF_OPCODE 5'h08
`define DRT_CA_SCOPE_BIT 5
`define DRT_TMR_W 4
`define DRT_CLK_PERIOD_PS 40000
`define DRT_SB_CYCLE_NS 90
`define DRT_AB_CYCLE_NS 180
`define DRT_SB_CYCLES ((`DRT_SB_CYCLE_NS * 1000 + `DRT_CLK_PERIOD_PS - 1) / `DRT_CLK_PERIOD_PS)
`define DRT_AB_CYCLES ((`DRT_AB_CYCLE_NS * 1000 + `DRT_CLK_PERIOD_PS - 1) / `DRT_CLK_PERIOD_PS)

`endif

// >>> common/drt_pkg.sv
package drt_pkg;
   typedef enum logic {DRT_DEC_IDLE, DRT_DEC_SECOND} drt_dec_state_t;
endpackage : drt_pkg

// >>> core/drt_cmd_decode.sv
`timescale 1ns/1ps
`include "drt_consts.svh"

module drt_cmd_decode (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic chipSelect,
   input wire logic [`DRT_CA_W-1:0] cmdAddr,
   output logic refPbStrobe,
   output logic refAbStrobe,
   output logic [`DRT_BANK_W-1:0] refBankSel
);
   logic csMeta_q;
   logic csSync_q;
   logic [`DRT_CA_W-1:0] caMeta_q;
   logic [`DRT_CA_W-1:0] caSync_q;
   drt_pkg::drt_dec_state_t state_q, state_d;
   logic scope_q, scope_d;
   logic pb_q, pb_d;
   logic ab_q, ab_d;
   logic [`DRT_BANK_W-1:0] bank_q, bank_d;
   logic firstEdge;

   assign firstEdge = csSync_q && (caSync_q[4:0] == `DRT_REF_OPCODE);

   always_comb begin
      state_d = state_q;
      scope_d = scope_q;
      pb_d = 1'b0;
      ab_d = 1'b0;
      bank_d = bank_q;
      case (state_q)
         drt_pkg::DRT_DEC_IDLE: begin
            if (firstEdge) begin
               state_d = drt_pkg::DRT_DEC_SECOND;
               scope_d = caSync_q[`DRT_CA_SCOPE_BIT];
            end
         end
         drt_pkg::DRT_DEC_SECOND: begin
            state_d = drt_pkg::DRT_DEC_IDLE;
            if (scope_q) begin
               ab_d = 1'b1;
            end else begin
               pb_d = 1'b1;
               bank_d = caSync_q[`DRT_BANK_W-1:0];
            end
         end
         default: state_d = drt_pkg::DRT_DEC_IDLE;
      endcase
   end

   // Pins are asynchronous to core_clk, hence two stages before decoding
   always_ff @(posedge core_clk) begin
      csMeta_q <= chipSelect;
      csSync_q <= csMeta_q;
      caMeta_q <= cmdAddr;
      caSync_q <= caMeta_q;
      if (sys_rst) begin
         state_q <= drt_pkg::DRT_DEC_IDLE;
         scope_q <= 1'b0;
         pb_q <= 1'b0;
         ab_q <= 1'b0;
         bank_q <= `DRT_BANK_RESET;
      end else begin
         state_q <= state_d;
         scope_q <= scope_d;
         pb_q <= pb_d;
         ab_q <= ab_d;
         bank_q <= bank_d;
      end
   end

   assign refPbStrobe = pb_q;
   assign refAbStrobe = ab_q;
   assign refBankSel = bank_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_ref_recognise: assert property ((state_q == drt_pkg::DRT_DEC_IDLE && firstEdge)
      |=> ##1 (refPbStrobe != refAbStrobe)) else $error("refresh opcode not turned into one strobe");
   a_no_false_ref: assert property ((state_q == drt_pkg::DRT_DEC_IDLE && !firstEdge)
      |=> ##1 (!refPbStrobe && !refAbStrobe)) else $error("strobe without refresh opcode");
   a_scope_all: assert property ((state_q == drt_pkg::DRT_DEC_IDLE && firstEdge && caSync_q[5])
      |=> ##1 refAbStrobe) else $error("scope high did not give all-bank refresh");
   a_bank_second: assert property ((state_q == drt_pkg::DRT_DEC_IDLE && firstEdge && !caSync_q[5])
      ##1 1'b1 |=> (refPbStrobe && refBankSel == $past(caSync_q[2:0]))) else $error("bank not from second edge");
endmodule : drt_cmd_decode

// >>> core/drt_refresh_tracker.sv
`timescale 1ns/1ps
`include "drt_consts.svh"

module drt_refresh_tracker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic chipSelect,
   input wire logic [`DRT_CA_W-1:0] cmdAddr,
   input wire logic selfRefreshExit,
   input wire logic actStrobe,
   input wire logic [`DRT_BANK_W-1:0] actBank,
   input wire logic preStrobe,
   input wire logic [`DRT_BANK_W-1:0] preBank,
   input wire logic preAll,
   output logic refStart,
   output logic refAllBanks,
   output logic [`DRT_BANK_W-1:0] refBank,
   output logic [`DRT_ROW_W-1:0] refRow,
   output logic [`DRT_BANK_W-1:0] bankCount,
   output logic [`DRT_ROW_W-1:0] rowCount,
   output logic [`DRT_NUM_BANKS-1:0] bankBusy,
   output logic [`DRT_NUM_BANKS-1:0] bankOpen
);
   localparam int SbInt = `DRT_SB_CYCLES;
   localparam int AbInt = `DRT_AB_CYCLES;
   localparam logic [`DRT_TMR_W-1:0] SbLoad = SbInt[`DRT_TMR_W-1:0];
   localparam logic [`DRT_TMR_W-1:0] AbLoad = AbInt[`DRT_TMR_W-1:0];
   localparam logic [`DRT_TMR_W-1:0] TmrOne = 4'h1;
   localparam logic [`DRT_TMR_W-1:0] TmrZero = 4'h0;

   logic pbStr;
   logic abStr;
   logic [`DRT_BANK_W-1:0] decBank;

   logic [`DRT_BANK_W-1:0] bankCnt_q, bankCnt_d;
   logic [`DRT_ROW_W-1:0] rowCnt_q, rowCnt_d;
   logic start_q, start_d;
   logic all_q, all_d;
   logic [`DRT_BANK_W-1:0] bank_q, bank_d;
   logic [`DRT_ROW_W-1:0] row_q, row_d;
   logic [`DRT_NUM_BANKS-1:0] busy_q, busy_d;
   logic [`DRT_NUM_BANKS-1:0] open_q, open_d;
   // High until the first single-bank refresh after a sync event
   logic fresh_q, fresh_d;

   drt_cmd_decode u_decode (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .chipSelect(chipSelect),
      .cmdAddr(cmdAddr),
      .refPbStrobe(pbStr),
      .refAbStrobe(abStr),
      .refBankSel(decBank)
   );

   // Counters and the per-command report
   always_comb begin
      bankCnt_d = bankCnt_q;
      rowCnt_d = rowCnt_q;
      start_d = 1'b0;
      all_d = all_q;
      bank_d = bank_q;
      row_d = row_q;
      fresh_d = fresh_q;
      if (abStr) begin
         start_d = 1'b1;
         all_d = 1'b1;
         row_d = rowCnt_q;
         rowCnt_d = rowCnt_q + 16'h0001;
         bankCnt_d = `DRT_BANK_RESET;
         fresh_d = 1'b1;
      end else if (pbStr) begin
         start_d = 1'b1;
         all_d = 1'b0;
         bank_d = decBank;
         row_d = rowCnt_q;
         bankCnt_d = bankCnt_q + 3'h1;
         fresh_d = 1'b0;
         if (bankCnt_q == `DRT_LAST_BANK) begin
            rowCnt_d = rowCnt_q + 16'h0001;
         end
      end
      // Exit from self refresh restarts the set; the row keeps its place
      if (selfRefreshExit) begin
         bankCnt_d = `DRT_BANK_RESET;
         fresh_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bankCnt_q <= `DRT_BANK_RESET;
         rowCnt_q <= `DRT_ROW_RESET;
         start_q <= 1'b0;
         all_q <= 1'b0;
         bank_q <= `DRT_BANK_RESET;
         row_q <= `DRT_ROW_RESET;
         fresh_q <= 1'b1;
      end else begin
         bankCnt_q <= bankCnt_d;
         rowCnt_q <= rowCnt_d;
         start_q <= start_d;
         all_q <= all_d;
         bank_q <= bank_d;
         row_q <= row_d;
         fresh_q <= fresh_d;
      end
   end

   // Per-bank refresh timer and open-row state
   for (genvar i = 0; i < `DRT_NUM_BANKS; i++) begin : g_bank
      localparam logic [`DRT_BANK_W-1:0] BankId = (`DRT_BANK_W)'(i);
      logic [`DRT_TMR_W-1:0] tmr_q, tmr_d;

      always_comb begin
         tmr_d = tmr_q;
         open_d[i] = open_q[i];
         if (tmr_q != TmrZero) begin
            tmr_d = tmr_q - TmrOne;
         end
         if (abStr) begin
            tmr_d = AbLoad;
         end else if (pbStr && decBank == BankId) begin
            tmr_d = SbLoad;
         end
         busy_d[i] = (tmr_d != TmrZero);
         if (preStrobe && (preAll || preBank == BankId)) begin
            open_d[i] = 1'b0;
         end
         // An activate aimed at a bank under refresh is dropped
         if (actStrobe && actBank == BankId && !busy_q[i]) begin
            open_d[i] = 1'b1;
         end
         if (tmr_q == TmrOne) begin
            open_d[i] = 1'b0;
         end
      end

      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            tmr_q <= TmrZero;
            busy_q[i] <= 1'b0;
            open_q[i] <= 1'b0;
         end else begin
            tmr_q <= tmr_d;
            busy_q[i] <= busy_d[i];
            open_q[i] <= open_d[i];
         end
      end

      a_target_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
         (pbStr && !abStr && decBank == BankId)
         |=> busy_q[i] [*3] ##1 !busy_q[i]) else $error("refreshed bank busy window wrong");
      a_other_free: assert property (@(posedge core_clk) disable iff (sys_rst)
         (pbStr && !abStr && decBank != BankId && !busy_q[i])
         |=> !busy_q[i]) else $error("untargeted bank made busy");
      a_idle_after: assert property (@(posedge core_clk) disable iff (sys_rst)
         $fell(busy_q[i]) |-> !open_q[i]) else $error("bank not idle after refresh");
   end

   assign refStart = start_q;
   assign refAllBanks = all_q;
   assign refBank = bank_q;
   assign refRow = row_q;
   assign bankCount = bankCnt_q;
   assign rowCount = rowCnt_q;
   assign bankBusy = busy_q;
   assign bankOpen = open_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_ab_window;
      (bankBusy == 8'hFF) [*5] ##1 (bankBusy == 8'h00 && bankOpen == 8'h00);
   endsequence

   a_exit_clears: assert property (selfRefreshExit |=> bankCount == 3'h0)
      else $error("self-refresh exit left bank counter nonzero");
   a_set_start: assert property ((fresh_q && pbStr && !abStr && !selfRefreshExit) |=> bankCount == 3'h1)
      else $error("set did not start at first refresh after sync");
   a_ab_clears: assert property (abStr |=> (bankCount == 3'h0 && refAllBanks && refStart
      && refRow == $past(rowCount))) else $error("all-bank refresh report wrong");
   a_ab_row_next: assert property (abStr |=> rowCount == $past(rowCount) + 16'h0001)
      else $error("row not advanced after all-bank refresh");
   a_pb_bank_step: assert property ((pbStr && !abStr && !selfRefreshExit)
      |=> bankCount == $past(bankCount) + 3'h1) else $error("bank counter step wrong");
   a_pb_row_step: assert property ((pbStr && !abStr && bankCount != 3'h7)
      |=> rowCount == $past(rowCount)) else $error("row moved inside a set");
   a_set_row_wrap: assert property ((pbStr && !abStr && bankCount == 3'h7)
      |=> rowCount == $past(rowCount) + 16'h0001) else $error("row not advanced at set end");
   a_ab_all_busy: assert property (abStr |=> s_ab_window)
      else $error("all-bank refresh window wrong");
endmodule : drt_refresh_tracker

// >>> verification/drt_host_model.sv
`timescale 1ns/1ps
`include "drt_consts.svh"

module drt_host_model (
   input wire logic core_clk,
   input wire logic selfRefreshExit,
   output logic chipSelect,
   output logic [`DRT_CA_W-1:0] cmdAddr
);
   int cyc = 0;
   int readyAt = 0;
   int exitSeen = 0;
   int exitTaken = 0;
   logic driving = 1'b0;
   logic [`DRT_NUM_BANKS-1:0] doneMask = 8'h00;

   initial begin
      chipSelect = 1'b0;
      cmdAddr = 6'h00;
   end

   // Released cmdAddr pins never keep their last value, so a stale level cannot pass as a command
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (!driving) cmdAddr <= ~cmdAddr;
      if (selfRefreshExit) exitSeen <= exitSeen + 1;
   end

   task automatic send_cmd(input logic [`DRT_CA_W-1:0] first, input logic [`DRT_CA_W-1:0] second);
      logic isRef;
      isRef = (first[4:0] == `DRT_REF_OPCODE);
      while (isRef && cyc < readyAt) @(posedge core_clk);
      if (exitSeen != exitTaken || (isRef && first[5]) || &doneMask) doneMask = 8'h00;
      exitTaken = exitSeen;
      // Claimed before the edge, so the idle toggling never writes the pins in the same step
      driving = 1'b1;
      @(posedge core_clk);
      chipSelect <= 1'b1;
      cmdAddr <= first;
      @(posedge core_clk);
      chipSelect <= 1'b0;
      cmdAddr <= second;
      if (isRef && !first[5]) doneMask[second[2:0]] = 1'b1;
      readyAt = cyc + ((isRef && first[5]) ? `DRT_AB_CYCLES : `DRT_SB_CYCLES) + 1;
      @(posedge core_clk);
      driving = 1'b0;
   endtask : send_cmd
endmodule : drt_host_model

// >>> verification/drt_refresh_tracker_tb.sv
`timescale 1ns/1ps
`include "drt_consts.svh"

module drt_refresh_tracker_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic chipSelect;
   logic [`DRT_CA_W-1:0] cmdAddr;
   logic selfRefreshExit = 1'b0;
   logic actStrobe = 1'b0;
   logic preStrobe = 1'b0;
   logic preAll = 1'b0;
   logic [2:0] actBank = 3'h0;
   logic [2:0] preBank = 3'h0;
   logic refStart, refAllBanks;
   logic [2:0] refBank, bankCount;
   logic [15:0] refRow, rowCount;
   logic [7:0] bankBusy, bankOpen;
   logic [15:0] expRow = 16'h0000;
   logic [2:0] expCount = 3'h0;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   always #20 core_clk = ~core_clk;

   drt_host_model u_host (.core_clk(core_clk), .selfRefreshExit(selfRefreshExit),
      .chipSelect(chipSelect), .cmdAddr(cmdAddr));

   drt_refresh_tracker u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .chipSelect(chipSelect),
      .cmdAddr(cmdAddr), .selfRefreshExit(selfRefreshExit), .actStrobe(actStrobe), .actBank(actBank),
      .preStrobe(preStrobe), .preBank(preBank), .preAll(preAll), .refStart(refStart),
      .refAllBanks(refAllBanks), .refBank(refBank), .refRow(refRow), .bankCount(bankCount),
      .rowCount(rowCount), .bankBusy(bankBusy), .bankOpen(bankOpen));

   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic wait_start(output logic seen);
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(posedge core_clk);
         #1;
         seen = (refStart === 1'b1);
      end
   endtask : wait_start

   // Kind bits: preAll, self-refresh exit, precharge, activate
   task automatic pulse(input logic [3:0] kind, input logic [2:0] b);
      @(posedge core_clk);
      {preAll, selfRefreshExit, preStrobe, actStrobe} <= kind;
      actBank <= b;
      preBank <= b;
      @(posedge core_clk);
      {preAll, selfRefreshExit, preStrobe, actStrobe} <= 4'h0;
      #1;
   endtask : pulse

   task automatic do_ref(input logic allb, input logic [2:0] bank);
      logic seen;
      u_host.send_cmd({allb, `DRT_REF_OPCODE}, {3'h0, bank});
      wait_start(seen);
      check_val("refStart", 16'h0001, {15'h0000, seen});
      check_val("refAllBanks", {15'h0000, allb}, {15'h0000, refAllBanks});
      check_val("refRow", expRow, refRow);
      if (allb) begin
         expCount = 3'h0;
         expRow++;
         check_val("bankBusy", 16'h00FF, {8'h00, bankBusy});
      end else begin
         check_val("refBank", {13'h0000, bank}, {13'h0000, refBank});
         check_val("bankBusy", 16'h0001 << bank, {8'h00, bankBusy});
         expCount++;
         if (expCount == 3'h0) expRow++;
      end
      check_val("bankCount", {13'h0000, expCount}, {13'h0000, bankCount});
      check_val("rowCount", expRow, rowCount);
      repeat (allb ? `DRT_AB_CYCLES : `DRT_SB_CYCLES) @(posedge core_clk);
      #1;
      check_val("bankBusy", 16'h0000, {8'h00, bankBusy});
      check_val("bankOpen", 16'h0000, allb ? {8'h00, bankOpen} : {15'h0000, bankOpen[bank]});
   endtask : do_ref

   task automatic t_reset();
      check_val("bankCount", 16'h0000, {13'h0000, bankCount});
      check_val("rowCount", 16'h0000, rowCount);
      check_val("bankOpen", 16'h0000, {8'h00, bankOpen});
   endtask : t_reset

   task automatic t_bad();
      logic seen;
      for (int i = 0; i < 5; i++) begin
         u_host.send_cmd(6'h08 ^ (6'h01 << i), 6'h00);
         wait_start(seen);
         check_val("refStart", 16'h0000, {15'h0000, seen});
      end
   endtask : t_bad

   task automatic t_set();
      logic [2:0] order [8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
      foreach (order[i]) do_ref(1'b0, order[i]);
   endtask : t_set

   task automatic t_sr_exit();
      do_ref(1'b0, 3'h2);
      do_ref(1'b0, 3'h4);
      pulse(4'h4, 3'h0);
      expCount = 3'h0;
      check_val("bankCount", 16'h0000, {13'h0000, bankCount});
      do_ref(1'b0, 3'h4);
   endtask : t_sr_exit

   task automatic t_banks();
      pulse(4'h1, 3'h2);
      pulse(4'h1, 3'h5);
      check_val("bankOpen", 16'h0024, {8'h00, bankOpen});
      pulse(4'h2, 3'h5);
      repeat (2) @(posedge core_clk);
      do_ref(1'b0, 3'h5);
      check_val("bankOpen", 16'h0004, {8'h00, bankOpen});
   endtask : t_banks

   task automatic t_ab();
      do_ref(1'b0, 3'h6);
      pulse(4'hA, 3'h0);
      check_val("bankOpen", 16'h0000, {8'h00, bankOpen});
      repeat (2) @(posedge core_clk);
      do_ref(1'b1, 3'h0);
      do_ref(1'b0, 3'h6);
   endtask : t_ab

   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset();
      t_bad();
      t_set();
      t_sr_exit();
      t_banks();
      t_ab();
      report_and_stop();
   end
endmodule : drt_refresh_tracker_tb
